// *** rtl/irq_ctrl_pkg.sv ***
// constants and types shared by the two-level interrupt controller
package irq_ctrl_pkg;

    localparam int NUM_SRC = 11;

    // special function register addresses
    localparam logic [7:0] ADDR_MAIN_ENABLE = 8'hA8;
    localparam logic [7:0] ADDR_MAIN_PRIORITY = 8'hB8;
    localparam logic [7:0] ADDR_SECONDARY = 8'hA9;

    // values after reset
    localparam logic [7:0] RESET_MAIN_ENABLE = 8'h00;
    localparam logic [7:0] RESET_MAIN_PRIORITY = 8'h00;
    localparam logic [7:0] RESET_SECONDARY = 8'hA0;

    // main enable / main priority bit positions
    localparam int BIT_GLOBAL_ENABLE = 7;
    localparam int BIT_CONVERTER = 6;
    localparam int BIT_TIMER_TWO = 5;
    localparam int BIT_UART = 4;
    localparam int BIT_TIMER_ONE = 3;
    localparam int BIT_EXTERNAL_ONE = 2;
    localparam int BIT_TIMER_ZERO = 1;
    localparam int BIT_EXTERNAL_ZERO = 0;

    // secondary register bit positions
    localparam int BIT_INTERVAL_COUNTER_PRIORITY = 6;
    localparam int BIT_SUPPLY_MONITOR_PRIORITY = 5;
    localparam int BIT_SYNC_SERIAL_PRIORITY = 4;
    localparam int BIT_SECONDARY_RESERVED = 3;
    localparam int BIT_INTERVAL_COUNTER_ENABLE = 2;
    localparam int BIT_SUPPLY_MONITOR_ENABLE = 1;
    localparam int BIT_SYNC_SERIAL_ENABLE = 0;

    // source index = polling order, 0 wins ties
    localparam int SRC_SUPPLY_MONITOR = 0;
    localparam int SRC_WATCHDOG = 1;
    localparam int SRC_EXTERNAL_ZERO = 2;
    localparam int SRC_CONVERTER = 3;
    localparam int SRC_TIMER_ZERO = 4;
    localparam int SRC_EXTERNAL_ONE = 5;
    localparam int SRC_TIMER_ONE = 6;
    localparam int SRC_SYNC_SERIAL = 7;
    localparam int SRC_UART = 8;
    localparam int SRC_TIMER_TWO = 9;
    localparam int SRC_INTERVAL_COUNTER = 10;

    // vector addresses
    localparam logic [15:0] VEC_EXTERNAL_ZERO = 16'h0003;
    localparam logic [15:0] VEC_TIMER_ZERO = 16'h000B;
    localparam logic [15:0] VEC_EXTERNAL_ONE = 16'h0013;
    localparam logic [15:0] VEC_TIMER_ONE = 16'h001B;
    localparam logic [15:0] VEC_UART = 16'h0023;
    localparam logic [15:0] VEC_TIMER_TWO = 16'h002B;
    localparam logic [15:0] VEC_CONVERTER = 16'h0033;
    localparam logic [15:0] VEC_SYNC_SERIAL = 16'h003B;
    localparam logic [15:0] VEC_SUPPLY_MONITOR = 16'h0043;
    localparam logic [15:0] VEC_INTERVAL_COUNTER = 16'h0053;
    localparam logic [15:0] VEC_WATCHDOG = 16'h005B;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_PUSH = 3'b010,
        SEQ_LOAD = 3'b100
    } seq_state_t;

endpackage

// *** rtl/irq_first_select.sv ***
// fixed-order picker: lowest index among the asserted requests
`timescale 1ns/1ps
module irq_first_select #(
    parameter int WIDTH = 11,
    parameter int IDX_W = 4
) (
    // requests
    input wire logic [WIDTH-1:0] req_i,
    // result
    output logic found_o,
    output logic [IDX_W-1:0] index_o
);

    always_comb begin
        found_o = 1'b0;
        index_o = '0;
        for (int i = WIDTH - 1; i >= 0; i--) begin
            if (req_i[i]) begin
                found_o = 1'b1;
                index_o = IDX_W'(i);
            end
        end
    end

endmodule

// *** rtl/two_level_interrupt_controller.sv ***
// two-level prioritised interrupt controller with vector sequencing for the core
`timescale 1ns/1ps
module two_level_interrupt_controller
    import irq_ctrl_pkg::*;
#(
    parameter int IDX_W = 4,
    parameter int WDT_SETTING_W = 4
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // special function register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    // peripheral request levels
    input wire logic supply_monitor_request_i,
    input wire logic external_request_zero_i,
    input wire logic [1:0] converter_ready_requests_i,
    input wire logic timer_zero_overflow_i,
    input wire logic external_request_one_i,
    input wire logic timer_one_overflow_i,
    input wire logic two_wire_serial_request_i,
    input wire logic four_wire_serial_request_i,
    input wire logic uart_receive_flag_i,
    input wire logic uart_transmit_flag_i,
    input wire logic timer_two_overflow_i,
    input wire logic timer_two_external_flag_i,
    input wire logic interval_counter_request_i,
    // watchdog
    input wire logic watchdog_request_i,
    input wire logic watchdog_irq_select_i,
    input wire logic [WDT_SETTING_W-1:0] watchdog_timeout_setting_i,
    output logic watchdog_reset_o,
    // core sequencing
    input wire logic core_boundary_i,
    input wire logic push_done_i,
    input wire logic reti_i,
    output logic pc_push_o,
    output logic pc_load_o,
    output logic [15:0] pc_vector_o,
    output logic [NUM_SRC-1:0] irq_taken_o,
    output logic [1:0] in_service_o
);

    // vector of a source index
    function automatic logic [15:0] vector_of(input logic [IDX_W-1:0] idx);
        logic [15:0] v;
        v = VEC_SUPPLY_MONITOR;
        case (int'(idx))
            SRC_SUPPLY_MONITOR: v = VEC_SUPPLY_MONITOR;
            SRC_WATCHDOG: v = VEC_WATCHDOG;
            SRC_EXTERNAL_ZERO: v = VEC_EXTERNAL_ZERO;
            SRC_CONVERTER: v = VEC_CONVERTER;
            SRC_TIMER_ZERO: v = VEC_TIMER_ZERO;
            SRC_EXTERNAL_ONE: v = VEC_EXTERNAL_ONE;
            SRC_TIMER_ONE: v = VEC_TIMER_ONE;
            SRC_SYNC_SERIAL: v = VEC_SYNC_SERIAL;
            SRC_UART: v = VEC_UART;
            SRC_TIMER_TWO: v = VEC_TIMER_TWO;
            SRC_INTERVAL_COUNTER: v = VEC_INTERVAL_COUNTER;
            default: v = VEC_SUPPLY_MONITOR;
        endcase
        return v;
    endfunction

    // one-hot of a source index
    function automatic logic [NUM_SRC-1:0] onehot_of(input logic [IDX_W-1:0] idx);
        logic [NUM_SRC-1:0] o;
        o = '0;
        o[idx] = 1'b1;
        return o;
    endfunction

    // ---------------- registers ----------------
    logic [7:0] main_enable_reg, main_enable_next;
    logic [7:0] main_priority_reg, main_priority_next;
    logic [7:0] secondary_irq_enable_priority_reg, secondary_irq_enable_priority_next;
    logic [7:0] rdata_reg, rdata_next;

    always_comb begin
        main_enable_next = main_enable_reg;
        main_priority_next = main_priority_reg;
        secondary_irq_enable_priority_next = secondary_irq_enable_priority_reg;
        rdata_next = rdata_reg;
        if (sfr_wr_i) begin
            case (sfr_addr_i)
                ADDR_MAIN_ENABLE: main_enable_next = sfr_wdata_i;
                ADDR_MAIN_PRIORITY: main_priority_next = sfr_wdata_i;
                // bit 3 stored as written; software keeps it zero
                ADDR_SECONDARY: secondary_irq_enable_priority_next = sfr_wdata_i;
                default: ;
            endcase
        end
        if (sfr_rd_i) begin
            case (sfr_addr_i)
                ADDR_MAIN_ENABLE: rdata_next = main_enable_reg;
                ADDR_MAIN_PRIORITY: rdata_next = main_priority_reg;
                ADDR_SECONDARY: rdata_next = secondary_irq_enable_priority_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            main_enable_reg <= RESET_MAIN_ENABLE;
            main_priority_reg <= RESET_MAIN_PRIORITY;
            secondary_irq_enable_priority_reg <= RESET_SECONDARY;
            rdata_reg <= 8'h00;
        end else begin
            main_enable_reg <= main_enable_next;
            main_priority_reg <= main_priority_next;
            secondary_irq_enable_priority_reg <= secondary_irq_enable_priority_next;
            rdata_reg <= rdata_next;
        end
    end

    // ---------------- watchdog ----------------
    logic watchdog_pend_reg, watchdog_pend_next;
    logic watchdog_reset_reg, watchdog_reset_next;
    logic watchdog_taken;

    always_comb begin
        watchdog_pend_next = watchdog_pend_reg;
        watchdog_reset_next = 1'b0;
        if (watchdog_taken) begin
            watchdog_pend_next = 1'b0;
        end
        if (watchdog_request_i) begin
            if (!watchdog_irq_select_i) begin
                watchdog_reset_next = 1'b1;
            end else if (watchdog_timeout_setting_i != '0) begin
                watchdog_pend_next = 1'b1; // set wins over take
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            watchdog_pend_reg <= 1'b0;
            watchdog_reset_reg <= 1'b0;
        end else begin
            watchdog_pend_reg <= watchdog_pend_next;
            watchdog_reset_reg <= watchdog_reset_next;
        end
    end

    // ---------------- request qualification ----------------
    logic global_irq_enable;
    logic [NUM_SRC-1:0] raw_req, src_enable, src_high, ready;
    logic [NUM_SRC-1:0] high_req, low_req;

    always_comb begin
        global_irq_enable = main_enable_reg[BIT_GLOBAL_ENABLE];
        raw_req = '0;
        raw_req[SRC_SUPPLY_MONITOR] = supply_monitor_request_i;
        raw_req[SRC_WATCHDOG] = watchdog_pend_reg;
        raw_req[SRC_EXTERNAL_ZERO] = external_request_zero_i;
        raw_req[SRC_CONVERTER] = |converter_ready_requests_i;
        raw_req[SRC_TIMER_ZERO] = timer_zero_overflow_i;
        raw_req[SRC_EXTERNAL_ONE] = external_request_one_i;
        raw_req[SRC_TIMER_ONE] = timer_one_overflow_i;
        raw_req[SRC_SYNC_SERIAL] = two_wire_serial_request_i | four_wire_serial_request_i;
        raw_req[SRC_UART] = uart_receive_flag_i | uart_transmit_flag_i;
        raw_req[SRC_TIMER_TWO] = timer_two_overflow_i | timer_two_external_flag_i;
        raw_req[SRC_INTERVAL_COUNTER] = interval_counter_request_i;

        src_enable = '0;
        src_enable[SRC_SUPPLY_MONITOR] = secondary_irq_enable_priority_reg[BIT_SUPPLY_MONITOR_ENABLE];
        src_enable[SRC_SYNC_SERIAL] = secondary_irq_enable_priority_reg[BIT_SYNC_SERIAL_ENABLE];
        src_enable[SRC_INTERVAL_COUNTER] =
            secondary_irq_enable_priority_reg[BIT_INTERVAL_COUNTER_ENABLE];
        src_enable[SRC_EXTERNAL_ZERO] = main_enable_reg[BIT_EXTERNAL_ZERO];
        src_enable[SRC_CONVERTER] = main_enable_reg[BIT_CONVERTER];
        src_enable[SRC_TIMER_ZERO] = main_enable_reg[BIT_TIMER_ZERO];
        src_enable[SRC_EXTERNAL_ONE] = main_enable_reg[BIT_EXTERNAL_ONE];
        src_enable[SRC_TIMER_ONE] = main_enable_reg[BIT_TIMER_ONE];
        src_enable[SRC_UART] = main_enable_reg[BIT_UART];
        src_enable[SRC_TIMER_TWO] = main_enable_reg[BIT_TIMER_TWO];
        // global enable gates all sources but the watchdog
        src_enable = src_enable & {NUM_SRC{global_irq_enable}};
        // watchdog ignores the global enable; its select bit and a non-zero timeout setting enable it
        src_enable[SRC_WATCHDOG] = 1'b1;

        // priority bit 1 = high level
        src_high = '0;
        src_high[SRC_SUPPLY_MONITOR] =
            secondary_irq_enable_priority_reg[BIT_SUPPLY_MONITOR_PRIORITY];
        src_high[SRC_SYNC_SERIAL] = secondary_irq_enable_priority_reg[BIT_SYNC_SERIAL_PRIORITY];
        src_high[SRC_INTERVAL_COUNTER] =
            secondary_irq_enable_priority_reg[BIT_INTERVAL_COUNTER_PRIORITY];
        src_high[SRC_EXTERNAL_ZERO] = main_priority_reg[BIT_EXTERNAL_ZERO];
        src_high[SRC_CONVERTER] = main_priority_reg[BIT_CONVERTER];
        src_high[SRC_TIMER_ZERO] = main_priority_reg[BIT_TIMER_ZERO];
        src_high[SRC_EXTERNAL_ONE] = main_priority_reg[BIT_EXTERNAL_ONE];
        src_high[SRC_TIMER_ONE] = main_priority_reg[BIT_TIMER_ONE];
        src_high[SRC_UART] = main_priority_reg[BIT_UART];
        src_high[SRC_TIMER_TWO] = main_priority_reg[BIT_TIMER_TWO];
        src_high[SRC_WATCHDOG] = 1'b1;

        ready = raw_req & src_enable;
        high_req = ready & src_high;
        low_req = ready & ~src_high;
    end

    logic high_found, low_found;
    logic [IDX_W-1:0] high_idx, low_idx;

    // fixed order within each level
    irq_first_select #(
        .WIDTH(NUM_SRC),
        .IDX_W(IDX_W)
    ) u_high_select (
        .req_i(high_req),
        .found_o(high_found),
        .index_o(high_idx)
    );

    irq_first_select #(
        .WIDTH(NUM_SRC),
        .IDX_W(IDX_W)
    ) u_low_select (
        .req_i(low_req),
        .found_o(low_found),
        .index_o(low_idx)
    );

    // ---------------- sequencer and in-service tracking ----------------
    seq_state_t state_reg, state_next;
    logic [1:0] in_service_reg, in_service_next;
    logic [IDX_W-1:0] sel_idx_reg, sel_idx_next;
    logic sel_high_reg, sel_high_next;
    logic push_reg, push_next;
    logic load_reg, load_next;
    logic [15:0] vector_reg, vector_next;
    logic [NUM_SRC-1:0] taken_reg, taken_next;
    logic high_ok, low_ok;

    always_comb begin
        // high preempts low but never high
        high_ok = high_found && !in_service_reg[1];
        // low only when no level is active and no high is waiting
        low_ok = low_found && (in_service_reg == 2'b00) && !high_found;
        state_next = state_reg;
        in_service_next = in_service_reg;
        sel_idx_next = sel_idx_reg;
        sel_high_next = sel_high_reg;
        push_next = 1'b0;
        load_next = 1'b0;
        vector_next = vector_reg;
        taken_next = '0;
        watchdog_taken = 1'b0;
        if (reti_i) begin
            // most recent level is the highest one set
            if (in_service_reg[1]) begin
                in_service_next[1] = 1'b0;
            end else begin
                in_service_next[0] = 1'b0;
            end
        end
        case (state_reg)
            SEQ_IDLE: begin
                if (core_boundary_i && (high_ok || low_ok)) begin
                    sel_high_next = high_ok;
                    sel_idx_next = high_ok ? high_idx : low_idx;
                    push_next = 1'b1;
                    state_next = SEQ_PUSH;
                end
            end
            SEQ_PUSH: begin
                push_next = 1'b1;
                if (push_done_i) begin
                    // jump only once the push is done
                    push_next = 1'b0;
                    load_next = 1'b1;
                    vector_next = vector_of(sel_idx_reg);
                    taken_next = onehot_of(sel_idx_reg);
                    watchdog_taken = (int'(sel_idx_reg) == SRC_WATCHDOG);
                    if (sel_high_reg) begin
                        in_service_next[1] = 1'b1;
                    end else begin
                        in_service_next[0] = 1'b1;
                    end
                    state_next = SEQ_LOAD;
                end
            end
            SEQ_LOAD: begin
                state_next = SEQ_IDLE;
            end
            default: begin
                state_next = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state_reg <= SEQ_IDLE;
            in_service_reg <= 2'b00;
            sel_idx_reg <= '0;
            sel_high_reg <= 1'b0;
            push_reg <= 1'b0;
            load_reg <= 1'b0;
            vector_reg <= 16'h0000;
            taken_reg <= '0;
        end else begin
            state_reg <= state_next;
            in_service_reg <= in_service_next;
            sel_idx_reg <= sel_idx_next;
            sel_high_reg <= sel_high_next;
            push_reg <= push_next;
            load_reg <= load_next;
            vector_reg <= vector_next;
            taken_reg <= taken_next;
        end
    end

    assign sfr_rdata_o = rdata_reg;
    assign watchdog_reset_o = watchdog_reset_reg;
    assign pc_push_o = push_reg;
    assign pc_load_o = load_reg;
    assign pc_vector_o = vector_reg;
    assign irq_taken_o = taken_reg;
    assign in_service_o = in_service_reg;

endmodule

// *** tb/core_model.sv ***
// behavioural core: instruction boundary and program counter push handshake
`timescale 1ns/1ps
module core_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // handshake
    input wire logic pc_push_i,
    input wire logic [1:0] push_delay_i,
    output logic core_boundary_o,
    output logic push_done_o
);
    logic [1:0] wait_reg;
    logic [1:0] wait_next;
    logic ready_reg;
    // the stack write ends push_delay_i cycles after the request, before any jump
    assign push_done_o = pc_push_i && (wait_reg == push_delay_i);
    assign core_boundary_o = ready_reg;
    always_comb begin
        wait_next = (pc_push_i && !push_done_o) ? wait_reg + 2'h1 : 2'h0;
    end
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            wait_reg <= 2'h0;
            ready_reg <= 1'h0;
        end else begin
            wait_reg <= wait_next;
            ready_reg <= 1'h1;
        end
    end
endmodule

// *** tb/irq_ctrl_sva.sv ***
// assertion checker for the two-level interrupt controller
`timescale 1ns/1ps
module irq_ctrl_sva
    import irq_ctrl_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // watchdog
    input wire logic watchdog_request_i,
    input wire logic watchdog_irq_select_i,
    input wire logic watchdog_reset_o,
    // core sequencing
    input wire logic push_done_i,
    input wire logic reti_i,
    input wire logic pc_push_o,
    input wire logic pc_load_o,
    input wire logic [15:0] pc_vector_o,
    input wire logic [NUM_SRC-1:0] irq_taken_o,
    input wire logic [1:0] in_service_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    localparam logic [15:0] VEC_TAB [NUM_SRC] = '{VEC_SUPPLY_MONITOR, VEC_WATCHDOG, VEC_EXTERNAL_ZERO,
        VEC_CONVERTER, VEC_TIMER_ZERO, VEC_EXTERNAL_ONE, VEC_TIMER_ONE, VEC_SYNC_SERIAL, VEC_UART,
        VEC_TIMER_TWO, VEC_INTERVAL_COUNTER};
    logic [15:0] exp_vec;
    always_comb begin
        exp_vec = 16'h0000;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (irq_taken_o[i]) begin
                exp_vec = VEC_TAB[i];
            end
        end
    end
    AST_LOAD_AFTER_PUSH: assert property (pc_load_o |-> $past(pc_push_o) && $past(push_done_i))
        else $error("load without finished push");
    AST_PUSH_HELD: assert property (pc_push_o && !push_done_i |=> pc_push_o)
        else $error("push request dropped early");
    AST_PUSH_ENDS: assert property (pc_push_o && push_done_i |=> pc_load_o ##1 !pc_load_o && !pc_push_o)
        else $error("load does not follow push");
    AST_VECTOR: assert property (pc_load_o |-> $onehot(irq_taken_o) && pc_vector_o == exp_vec)
        else $error("wrong vector");
    AST_WDT_RESET: assert property (watchdog_request_i && !watchdog_irq_select_i |=> watchdog_reset_o)
        else $error("watchdog reset missing");
    AST_WDT_CAUSE: assert property (watchdog_reset_o |-> $past(watchdog_request_i) &&
        !$past(watchdog_irq_select_i))
        else $error("watchdog reset without cause");
    AST_WDT_HIGH: assert property (pc_load_o && irq_taken_o[SRC_WATCHDOG] |-> in_service_o[1])
        else $error("watchdog not high level");
    AST_NO_SAME_LEVEL: assert property ($rose(pc_push_o) |-> !$past(in_service_o[1]))
        else $error("high routine preempted");
    AST_LOW_PREEMPT: assert property ($rose(pc_push_o) && $past(in_service_o[0]) |->
        ##[1:8] pc_load_o ##0 in_service_o[1])
        else $error("low routine preempted by low request");
    AST_RETI_LOW: assert property (reti_i && !pc_push_o && !pc_load_o && in_service_o == 2'h1 |=>
        in_service_o == 2'h0)
        else $error("return did not clear low level");
    COV_WDT: cover property (pc_load_o && irq_taken_o[SRC_WATCHDOG]);
    COV_NESTED: cover property (pc_load_o && in_service_o == 2'h3);
    COV_WDT_RESET: cover property (watchdog_reset_o);
endmodule

bind two_level_interrupt_controller irq_ctrl_sva irq_ctrl_sva_i (
    .clk_i(clk_i), .rstn_i(rstn_i), .watchdog_request_i(watchdog_request_i),
    .watchdog_irq_select_i(watchdog_irq_select_i), .watchdog_reset_o(watchdog_reset_o),
    .push_done_i(push_done_i), .reti_i(reti_i), .pc_push_o(pc_push_o), .pc_load_o(pc_load_o),
    .pc_vector_o(pc_vector_o), .irq_taken_o(irq_taken_o), .in_service_o(in_service_o)
);

// *** tb/tb_top.sv ***
// self-checking testbench for the two-level interrupt controller
`timescale 1ns/1ps
module tb_top
    import irq_ctrl_pkg::*;
;
    logic clk_i = 1'h0;
    logic rstn_i = 1'h0;
    logic [7:0] sfr_addr_i = 8'h00;
    logic [7:0] sfr_wdata_i = 8'h00;
    logic sfr_wr_i = 1'h0;
    logic sfr_rd_i = 1'h0;
    logic [NUM_SRC-1:0] req = '0;
    logic alt = 1'h0;
    logic wd_sel = 1'h1;
    logic [3:0] wd_set = 4'h5;
    logic reti_i = 1'h0;
    logic [1:0] delay = 2'h0;
    logic [7:0] rdata;
    logic wd_rst, push, done, boundary, load;
    logic [15:0] vec;
    logic [NUM_SRC-1:0] taken;
    logic [1:0] in_svc;
    int mismatches = 0;
    int checked = 0;
    localparam logic [15:0] VEC_TAB [NUM_SRC] = '{VEC_SUPPLY_MONITOR, VEC_WATCHDOG, VEC_EXTERNAL_ZERO,
        VEC_CONVERTER, VEC_TIMER_ZERO, VEC_EXTERNAL_ONE, VEC_TIMER_ONE, VEC_SYNC_SERIAL, VEC_UART,
        VEC_TIMER_TWO, VEC_INTERVAL_COUNTER};
    // secondary byte, main enable byte per source
    localparam logic [15:0] ENA_TAB [NUM_SRC] = '{16'h0280, 16'h0000, 16'h0081, 16'h00C0, 16'h0082,
        16'h0084, 16'h0088, 16'h0180, 16'h0090, 16'h00A0, 16'h0480};

    always #2 clk_i = ~clk_i;

    two_level_interrupt_controller two_level_interrupt_controller_i (
        .clk_i(clk_i), .rstn_i(rstn_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
        .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(rdata), .supply_monitor_request_i(req[SRC_SUPPLY_MONITOR]),
        .external_request_zero_i(req[SRC_EXTERNAL_ZERO]),
        .converter_ready_requests_i({req[SRC_CONVERTER] & alt, req[SRC_CONVERTER] & ~alt}),
        .timer_zero_overflow_i(req[SRC_TIMER_ZERO]), .external_request_one_i(req[SRC_EXTERNAL_ONE]),
        .timer_one_overflow_i(req[SRC_TIMER_ONE]), .two_wire_serial_request_i(req[SRC_SYNC_SERIAL] & alt),
        .four_wire_serial_request_i(req[SRC_SYNC_SERIAL] & ~alt), .uart_receive_flag_i(req[SRC_UART] & alt),
        .uart_transmit_flag_i(req[SRC_UART] & ~alt), .timer_two_overflow_i(req[SRC_TIMER_TWO] & alt),
        .timer_two_external_flag_i(req[SRC_TIMER_TWO] & ~alt),
        .interval_counter_request_i(req[SRC_INTERVAL_COUNTER]), .watchdog_request_i(req[SRC_WATCHDOG]),
        .watchdog_irq_select_i(wd_sel), .watchdog_timeout_setting_i(wd_set), .watchdog_reset_o(wd_rst),
        .core_boundary_i(boundary), .push_done_i(done), .reti_i(reti_i), .pc_push_o(push),
        .pc_load_o(load), .pc_vector_o(vec), .irq_taken_o(taken), .in_service_o(in_svc)
    );

    core_model core_model_i (.clk_i(clk_i), .rstn_i(rstn_i), .pc_push_i(push), .push_delay_i(delay),
        .core_boundary_o(boundary), .push_done_o(done));

    task step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'h1;
        step(1);
        sfr_wr_i = 1'h0;
        step(1);
    endtask

    task rd_chk(input logic [7:0] a, input logic [7:0] exp);
        sfr_addr_i = a;
        sfr_rd_i = 1'h1;
        step(1);
        sfr_rd_i = 1'h0;
        chk("register", {8'h00, exp}, {8'h00, rdata});
        step(1);
    endtask

    task expect_load(input int src, input logic [1:0] svc);
        int n;
        n = 0;
        while (load !== 1'h1 && n < 12) begin
            step(1);
            n++;
        end
        chk("load", 16'h0001, {15'h0000, load});
        chk("vector", VEC_TAB[src], vec);
        chk("taken", 16'h0001 << src, {5'h00, taken});
        chk("in_service", {14'h0000, svc}, {14'h0000, in_svc});
    endtask

    task expect_quiet(input int cycles);
        logic seen;
        seen = 1'h0;
        repeat (cycles) begin
            step(1);
            seen = seen | (load === 1'h1);
        end
        chk("quiet", 16'h0000, {15'h0000, seen});
    endtask

    task finish_irq(input int src);
        req[src] = 1'h0;
        reti_i = 1'h1;
        step(1);
        reti_i = 1'h0;
        step(1);
    endtask

    task test_registers();
        rd_chk(ADDR_MAIN_ENABLE, 8'h00);
        rd_chk(ADDR_MAIN_PRIORITY, 8'h00);
        rd_chk(ADDR_SECONDARY, 8'hA0);
        rd_chk(8'h55, 8'h00);
        wr(ADDR_SECONDARY, 8'h77);
        rd_chk(ADDR_SECONDARY, 8'h77);
        wr(8'h55, 8'hFF);
        rd_chk(ADDR_MAIN_ENABLE, 8'h00);
    endtask

    task test_enables();
        wr(ADDR_SECONDARY, 8'h00);
        wr(ADDR_MAIN_ENABLE, 8'h7E);
        req[SRC_EXTERNAL_ZERO] = 1'h1;
        req[SRC_TIMER_ZERO] = 1'h1;
        expect_quiet(8);
        wr(ADDR_MAIN_ENABLE, 8'h80);
        expect_quiet(8);
        wr(ADDR_MAIN_ENABLE, 8'h83);
        expect_load(SRC_EXTERNAL_ZERO, 2'h1);
        finish_irq(SRC_EXTERNAL_ZERO);
        expect_load(SRC_TIMER_ZERO, 2'h1);
        finish_irq(SRC_TIMER_ZERO);
    endtask

    task test_vectors();
        for (int p = 0; p < 2; p++) begin
            delay = (p == 1) ? 2'h3 : 2'h0;
            wr(ADDR_MAIN_PRIORITY, (p == 1) ? 8'h7F : 8'h00);
            for (int s = 0; s < NUM_SRC; s++) begin
                alt = s[0];
                wr(ADDR_MAIN_ENABLE, ENA_TAB[s][7:0]);
                wr(ADDR_SECONDARY, ENA_TAB[s][15:8] | ((p == 1) ? 8'h70 : 8'h00));
                req[s] = 1'h1;
                if (s == SRC_WATCHDOG) begin
                    step(1);
                    req[s] = 1'h0;
                end
                expect_load(s, (p == 1 || s == SRC_WATCHDOG) ? 2'h2 : 2'h1);
                finish_irq(s);
            end
        end
    endtask

    task test_ties();
        wr(ADDR_MAIN_PRIORITY, 8'h00);
        wr(ADDR_SECONDARY, 8'h07);
        wr(ADDR_MAIN_ENABLE, 8'hFF);
        req = 11'h7FD;
        for (int s = 0; s < NUM_SRC; s++) begin
            if (s != SRC_WATCHDOG) begin
                expect_load(s, 2'h1);
                finish_irq(s);
            end
        end
    endtask

    task test_levels();
        wr(ADDR_MAIN_PRIORITY, 8'h08);
        req[SRC_EXTERNAL_ZERO] = 1'h1;
        req[SRC_TIMER_ONE] = 1'h1;
        expect_load(SRC_TIMER_ONE, 2'h2);
        req[SRC_TIMER_ONE] = 1'h0;
        wr(ADDR_MAIN_PRIORITY, 8'h0A);
        req[SRC_TIMER_ZERO] = 1'h1;
        expect_quiet(8);
        finish_irq(SRC_TIMER_ONE);
        expect_load(SRC_TIMER_ZERO, 2'h2);
        finish_irq(SRC_TIMER_ZERO);
        expect_load(SRC_EXTERNAL_ZERO, 2'h1);
        req[SRC_EXTERNAL_ZERO] = 1'h0;
        req[SRC_EXTERNAL_ONE] = 1'h1;
        expect_quiet(8);
        req[SRC_TIMER_ONE] = 1'h1;
        expect_load(SRC_TIMER_ONE, 2'h3);
        finish_irq(SRC_TIMER_ONE);
        chk("in_service", 16'h0001, {14'h0000, in_svc});
        finish_irq(SRC_EXTERNAL_ZERO);
        expect_load(SRC_EXTERNAL_ONE, 2'h1);
        finish_irq(SRC_EXTERNAL_ONE);
    endtask

    task test_watchdog();
        wr(ADDR_MAIN_ENABLE, 8'h00);
        wd_set = 4'h0;
        req[SRC_WATCHDOG] = 1'h1;
        step(1);
        req[SRC_WATCHDOG] = 1'h0;
        expect_quiet(8);
        wd_set = 4'h5;
        wd_sel = 1'h0;
        req[SRC_WATCHDOG] = 1'h1;
        step(1);
        req[SRC_WATCHDOG] = 1'h0;
        chk("watchdog_reset", 16'h0001, {15'h0000, wd_rst});
        expect_quiet(8);
    endtask

    task test_done();
        $display("comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        step(16);
        rstn_i = 1'h1;
        test_registers();
        test_enables();
        test_vectors();
        test_ties();
        test_levels();
        test_watchdog();
        test_done();
    end

    // the run needs about 400 cycles
    initial begin
        #40000;
        mismatches++;
        test_done();
    end
endmodule
